// *** gtc_pkg.sv ***
// Behaviour
// - 16-bit up counter read and written as two bytes; byte writes replace live count.
// - Source bit 0 counts instruction clock (clock/4); 1 counts external source.
// - External source is input pin, or with oscillator bit set the low-power oscillator, held low while i_lp_mode_ok is low.
// - Internal clock advances count once per prescaled instruction-clock period.
// - External counting increments on each rising edge of the input, after prescaling.
// - External clock counted synchronised or asynchronously, chosen by a control bit.
// - After enable, byte write or disable, a falling edge must precede counted rise.
// - Prescaler divides the selected clock by 1, 2, 4 or 8 via two-bit field.
// - Prescale counter is hidden and cleared by any count byte write.
// - Async bit set passes external clock to counter without synchronising.
// - Count rolls FFFF to 0000 and sets sticky overflow flag until cleared.
`default_nettype none
package gtc_pkg;
  typedef logic [15:0] gtc_count_type;
  // ===========================================================
  // Register map, byte addresses
  localparam logic [4:0] OFS_COUNT_LOW = 5'h00;
  localparam logic [4:0] OFS_COUNT_HIGH = 5'h04;
  localparam logic [4:0] OFS_CONTROL = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0C;
  localparam logic [4:0] OFS_MASK = 5'h10;
  // ===========================================================
  // Control, status and mask register fields
  localparam int BIT_ENABLE = 0;
  localparam int BIT_SOURCE = 1;
  localparam int BIT_ASYNC = 2;
  localparam int BIT_OSC_EN = 3;
  localparam int BIT_PRE_LO = 4;
  localparam int BIT_OVF = 0;
  localparam logic [5:0] CONTROL_RESET = 6'h00;
  localparam gtc_count_type COUNT_RESET = 16'h0000;
  localparam gtc_count_type COUNT_MAX = 16'hFFFF;
  // ===========================================================
  // Instruction clock is the system clock divided by four
  localparam int INSTR_DIV = 4;
  localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);

  function automatic logic [2:0] pre_last(input logic [1:0] sel);
    pre_last = 3'((4'h1 << sel) - 4'h1);
  endfunction
endpackage
`default_nettype wire

// *** gtc_pre_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface gtc_pre_if;
  logic clear;
  logic [1:0] sel;
  logic tick_in;
  logic tick_out;
  modport ctl (output clear, output sel, output tick_in, input tick_out);
  modport core (input clear, input sel, input tick_in, output tick_out);
endinterface
`default_nettype wire

// *** gtc_edge.sv ***
`timescale 1ns/100ps
`default_nettype none
module gtc_edge (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_src,
  input wire logic i_async,
  output logic o_rise,
  output logic o_fall
);
  logic sync1_r;
  logic sync2_r;
  logic sync2_d_r;
  logic raw_d_r;
  wire logic sync_rise = sync2_r & ~sync2_d_r;
  wire logic sync_fall = ~sync2_r & sync2_d_r;
  wire logic raw_rise = i_src & ~raw_d_r;
  wire logic raw_fall = ~i_src & raw_d_r;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync2_d_r <= 1'b0;
      raw_d_r <= 1'b0;
    end
    else
    begin
      sync1_r <= i_src;
      sync2_r <= sync1_r;
      sync2_d_r <= sync2_r;
      raw_d_r <= i_src;
    end
  end

  assign o_rise = i_async ? raw_rise : sync_rise;
  assign o_fall = i_async ? raw_fall : sync_fall;
endmodule // gtc_edge
`default_nettype wire

// *** gtc_prescaler.sv ***
`timescale 1ns/100ps
`default_nettype none
module gtc_prescaler (
  input wire logic i_clk,
  input wire logic i_arst_n,
  gtc_pre_if.core pre
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  wire logic [2:0] last = gtc_pkg::pre_last(pre.sel);
  // Spelled out again for the checks, not taken from the function
  wire logic [2:0] ratio_last = (pre.sel == 2'b00) ? 3'h0 : (pre.sel == 2'b01) ? 3'h1 :
                                (pre.sel == 2'b10) ? 3'h3 : 3'h7;

  assign pre.tick_out = pre.tick_in & ~pre.clear & (cnt_r >= last);
  assign cnt_nxt = pre.clear ? 3'h0 : pre.tick_out ? 3'h0 : pre.tick_in ? cnt_r + 3'h1 : cnt_r;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      cnt_r <= 3'h0;
    else
      cnt_r <= cnt_nxt;
  end

  AST_PRE_CLEAR: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      pre.clear |=> cnt_r == 3'h0) else $error("prescaler not cleared");
  // ratio mapping; a smaller ratio chosen mid-count fires at once
  AST_PRE_RATIO: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      pre.tick_out |-> cnt_r >= ratio_last)
      else $error("prescaler ratio wrong");
  AST_PRE_FIRE: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      pre.tick_in && !pre.clear && cnt_r == ratio_last |-> pre.tick_out)
      else $error("prescaler tick missed");
endmodule // gtc_prescaler
`default_nettype wire

// *** gtc_timer.sv ***
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module gtc_timer (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_external_count_input,
  input wire logic i_low_power_oscillator,
  input wire logic i_lp_mode_ok,
  output logic o_irq
);
  // ===========================================================
  // State
  gtc_pkg::gtc_count_type count_r;
  gtc_pkg::gtc_count_type count_nxt;
  logic [5:0] control_r;
  logic [5:0] control_nxt;
  logic status_r;
  logic status_nxt;
  logic mask_r;
  logic mask_nxt;
  logic armed_r;
  logic armed_nxt;
  logic [1:0] instr_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic irq_r;

  // ===========================================================
  // Bus decode
  // One wait cycle: request seen, then taken on the next edge.
  wire logic req = i_avs_read | i_avs_write;
  wire logic take = req & ~wait_r;
  wire logic wr_take = i_avs_write & take & i_avs_byteenable[0];
  wire logic rd_take = i_avs_read & take;
  wire logic hit_low = i_avs_address == gtc_pkg::OFS_COUNT_LOW;
  wire logic hit_high = i_avs_address == gtc_pkg::OFS_COUNT_HIGH;
  wire logic hit_ctl = i_avs_address == gtc_pkg::OFS_CONTROL;
  wire logic hit_stat = i_avs_address == gtc_pkg::OFS_STATUS;
  wire logic hit_mask = i_avs_address == gtc_pkg::OFS_MASK;
  wire logic wr_low = wr_take & hit_low;
  wire logic wr_high = wr_take & hit_high;
  wire logic cnt_wr = wr_low | wr_high;
  logic [31:0] rd_mux;

  assign rd_mux = hit_low ? {24'h000000, count_r[7:0]} :
                  hit_high ? {24'h000000, count_r[15:8]} :
                  hit_ctl ? {26'h0, control_r} :
                  hit_stat ? {31'h0, status_r} :
                  hit_mask ? {31'h0, mask_r} : 32'h00000000;

  // ===========================================================
  // Control fields
  wire logic en = control_r[gtc_pkg::BIT_ENABLE];
  wire logic ext_sel = control_r[gtc_pkg::BIT_SOURCE];
  wire logic async_sel = control_r[gtc_pkg::BIT_ASYNC];
  wire logic osc_sel = control_r[gtc_pkg::BIT_OSC_EN];
  wire logic [1:0] div_sel = control_r[gtc_pkg::BIT_PRE_LO +: 2];

  // ===========================================================
  // Clock source
  // pin or oscillator
  wire logic ext_src = osc_sel ? (i_low_power_oscillator & i_lp_mode_ok)
                               : i_external_count_input;
  logic ext_rise;
  logic ext_fall;

  gtc_edge u_edge (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_src(ext_src),
    .i_async(async_sel),
    .o_rise(ext_rise),
    .o_fall(ext_fall)
  );

  wire logic instr_tick = instr_r == gtc_pkg::INSTR_LAST;
  // rising edge only after a falling edge
  wire logic ext_tick = ext_rise & armed_r;
  wire logic src_tick = ext_sel ? ext_tick : instr_tick;

  gtc_pre_if pre ();
  assign pre.clear = cnt_wr;
  assign pre.sel = div_sel;
  assign pre.tick_in = src_tick & en;

  gtc_prescaler u_pre (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .pre(pre.core)
  );

  wire logic inc = pre.tick_out & ~cnt_wr;
  wire logic ovf = inc & (count_r == gtc_pkg::COUNT_MAX);

  // ===========================================================
  // Next state
  always_comb
  begin
    count_nxt = count_r;
    // byte writes replace the live count
    if (wr_low)
      count_nxt[7:0] = i_avs_writedata[7:0];
    else if (wr_high)
      count_nxt[15:8] = i_avs_writedata[7:0];
    else if (inc)
      count_nxt = count_r + 16'h0001;
  end

  assign control_nxt = (wr_take & hit_ctl) ? i_avs_writedata[5:0] : control_r;
  assign mask_nxt = (wr_take & hit_mask) ? i_avs_writedata[gtc_pkg::BIT_OVF] : mask_r;
  // sticky, read clears only what was seen; new event wins
  assign status_nxt = ovf | (status_r & ~(rd_take & hit_stat & rdata_r[gtc_pkg::BIT_OVF]));

  // disarm on disable or count write, arm on falling edge
  assign armed_nxt = (~en | cnt_wr) ? 1'b0 : (ext_fall ? 1'b1 : armed_r);

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      count_r <= gtc_pkg::COUNT_RESET;
      control_r <= gtc_pkg::CONTROL_RESET;
      status_r <= 1'b0;
      mask_r <= 1'b0;
      armed_r <= 1'b0;
      instr_r <= 2'h0;
    end
    else
    begin
      count_r <= count_nxt;
      control_r <= control_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      armed_r <= armed_nxt;
      instr_r <= instr_r + 2'h1;
    end
  end

  // ===========================================================
  // Bus answer and interrupt
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wait_r <= 1'b1;
      rdata_r <= 32'h00000000;
      irq_r <= 1'b0;
    end
    else
    begin
      wait_r <= ~(req & wait_r);
      rdata_r <= (req & wait_r) ? rd_mux : rdata_r;
      irq_r <= status_nxt & mask_nxt;
    end
  end

  assign o_avs_waitrequest = wait_r;
  assign o_avs_readdata = rdata_r;
  assign o_irq = irq_r;

  // ===========================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  AST_WR_LOW: assert property (wr_low |=> count_r[7:0] == $past(i_avs_writedata[7:0]))
    else $error("low byte write lost");
  AST_WR_HIGH: assert property (wr_high |=> count_r[15:8] == $past(i_avs_writedata[7:0]))
    else $error("high byte write lost");
  AST_INT_SRC: assert property (inc && !ext_sel |-> instr_tick)
    else $error("internal count off instruction tick");
  AST_OSC_MODE: assert property (inc && ext_sel && osc_sel
      |-> i_lp_mode_ok || $past(i_lp_mode_ok, 2))
    else $error("oscillator counted outside allowed mode");
  AST_INT_PERIOD: assert property (inc && !ext_sel && div_sel == 2'b00
      && !cnt_wr |=> !inc [*3])
    else $error("instruction clock rate wrong");
  AST_EXT_RISE: assert property (inc && ext_sel |-> ext_rise)
    else $error("external count without rising edge");
  AST_ASYNC_FAST: assert property (ext_sel && async_sel && en && armed_r
      && div_sel == 2'b00 && !cnt_wr && ext_src && !$past(ext_src) && $past(async_sel)
      |-> inc)
    else $error("async edge not counted at once");
  AST_ARMED: assert property (inc && ext_sel |-> armed_r)
    else $error("rise counted before fall");
  AST_DISARM: assert property (cnt_wr || !en |=> !armed_r)
    else $error("not disarmed");
  AST_SYNC_LAT: assert property (ext_sel && !async_sel && ext_rise |-> $past(ext_src, 2))
    else $error("sync path latency wrong");
  AST_ROLL: assert property (ovf |=> count_r == gtc_pkg::COUNT_RESET && status_r)
    else $error("rollover wrong");
  AST_HOLD: assert property (!en && !cnt_wr |=> count_r == $past(count_r))
    else $error("count moved while disabled");

  COV_ROLL: cover property (ovf);
  COV_EXT_INC: cover property (inc && ext_sel && !async_sel);
  COV_ASYNC_INC: cover property (inc && ext_sel && async_sel);
  COV_DIV8: cover property (inc && div_sel == 2'b11);
endmodule // gtc_timer
`default_nettype wire

// *** gtc_ext_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ===========================================================
// External clock source: bursts of whole periods, low half first
// Between bursts it holds the level the bench asks for, like a real pin
module gtc_ext_model #(
  parameter int HALF = 3,
  parameter int PERIODS = 5
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_go,
  input wire logic i_idle,
  output logic o_busy,
  output logic o_wave
);
  int cnt_r;
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      cnt_r <= 0;
    else if (i_go && cnt_r == 0)
      cnt_r <= 2 * HALF * PERIODS;
    else if (cnt_r != 0)
      cnt_r <= cnt_r - 1;
  end
  assign o_busy = (cnt_r != 0);
  assign o_wave = o_busy ? (((cnt_r - 1) % (2 * HALF)) < HALF) : i_idle;
endmodule // gtc_ext_model
`default_nettype wire

// *** gtc_timer_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module gtc_timer_tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic go = 1'b0;
  logic pin_idle = 1'b1;
  logic use_osc = 1'b0;
  logic lp_ok = 1'b0;
  logic [3:0] be = 4'hF;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, d, v;
  logic wq, irq, busy, wave;
  int error_cnt = 0;
  int checked = 0;
  int n;
  int exp_t[6] = '{5, 4, 5, 5, 0, 2};
  // Row bits: async, oscillator, oscillator allowed, idle pin level; last row divides by 2
  logic [3:0] cfg_t[6] = '{4'h1, 4'h0, 4'h9, 4'h7, 4'h5, 4'h1};
  gtc_timer dut_u (.i_clk(clk), .i_arst_n(arst_n), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wq),
    .i_external_count_input(use_osc ? 1'b0 : wave),
    .i_low_power_oscillator(use_osc ? wave : 1'b0), .i_lp_mode_ok(lp_ok), .o_irq(irq));
  gtc_ext_model ext_u (.i_clk(clk), .i_arst_n(arst_n), .i_go(go), .i_idle(pin_idle),
    .o_busy(busy), .o_wave(wave));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  task automatic close_out();
    if (error_cnt == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checked++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  // ===========================================================
  // Avalon access: hold until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] val);
    n = 0;
    addr <= a;
    wdata <= val;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wq !== 1'b0 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
    if (wq !== 1'b0)
    begin
      error_cnt++;
      close_out();
    end
    d = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // ===========================================================
  // Overflow with the mask off or on; flag is sticky either way
  task automatic ovf(input logic m);
    bus(1, gtc_pkg::OFS_MASK, {31'h0, m});
    bus(1, gtc_pkg::OFS_CONTROL, 32'h0);
    bus(1, gtc_pkg::OFS_COUNT_HIGH, 32'hFF);
    bus(1, gtc_pkg::OFS_COUNT_LOW, 32'hFE);
    bus(1, gtc_pkg::OFS_CONTROL, 32'h1);
    n = 0;
    while (irq !== 1'b1 && n < 40)
    begin
      n++;
      @(posedge clk);
    end
    chk({31'h0, irq}, {31'h0, m}, {31'h0, m});
    bus(1, gtc_pkg::OFS_CONTROL, 32'h0);
    bus(0, gtc_pkg::OFS_STATUS, 32'h0);
    chk(d, 32'h1, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0, 32'h0);
    bus(0, gtc_pkg::OFS_STATUS, 32'h0);
    chk(d, 32'h0, 32'h0);
    bus(0, gtc_pkg::OFS_COUNT_HIGH, 32'h0);
    chk(d, 32'h0, 32'h0);
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    // ===========================================================
    // reset values, byte access, refused writes
    bus(0, gtc_pkg::OFS_CONTROL, 32'h0);
    chk(d, 32'h0, 32'h0);
    bus(1, gtc_pkg::OFS_COUNT_HIGH, 32'hA5);
    bus(1, gtc_pkg::OFS_COUNT_LOW, 32'h3C);
    bus(0, gtc_pkg::OFS_COUNT_HIGH, 32'h0);
    chk(d, 32'hA5, 32'hA5);
    bus(0, gtc_pkg::OFS_COUNT_LOW, 32'h0);
    chk(d, 32'h3C, 32'h3C);
    bus(1, gtc_pkg::OFS_CONTROL, 32'h3E);
    be <= 4'h0;
    bus(1, gtc_pkg::OFS_CONTROL, 32'h0);
    be <= 4'hF;
    bus(0, gtc_pkg::OFS_CONTROL, 32'h0);
    chk(d, 32'h3E, 32'h3E);
    bus(1, 5'h14, 32'hFF);
    bus(0, 5'h14, 32'h0);
    chk(d, 32'h0, 32'h0);
    ovf(1'b0);
    ovf(1'b1);
    // ===========================================================
    // prescale ratios on the instruction clock
    for (int s = 0; s < 4; s++)
    begin
      bus(1, gtc_pkg::OFS_CONTROL, 32'h0);
      bus(1, gtc_pkg::OFS_COUNT_LOW, 32'h0);
      bus(1, gtc_pkg::OFS_COUNT_HIGH, 32'h0);
      bus(1, gtc_pkg::OFS_CONTROL, 32'h1 | (s << 4));
      repeat (96) @(posedge clk);
      bus(1, gtc_pkg::OFS_CONTROL, 32'h0);
      bus(0, gtc_pkg::OFS_COUNT_LOW, 32'h0);
      chk(d, 96 / (4 << s) - 1, 96 / (4 << s) + 1);
    end
    v = d;
    repeat (40) @(posedge clk);
    bus(0, gtc_pkg::OFS_COUNT_LOW, 32'h0);
    chk(d, v, v);
    // ===========================================================
    // external pin, oscillator, async path, arming edge
    for (int r = 0; r < 6; r++)
    begin
      {use_osc, lp_ok, pin_idle} <= cfg_t[r][2:0];
      bus(1, gtc_pkg::OFS_CONTROL, 32'h0);
      bus(1, gtc_pkg::OFS_COUNT_LOW, 32'h0);
      bus(1, gtc_pkg::OFS_COUNT_HIGH, 32'h0);
      bus(1, gtc_pkg::OFS_CONTROL, {26'h0, (r == 5) ? 2'h1 : 2'h0, cfg_t[r][2], cfg_t[r][3], 2'h3});
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (40) @(posedge clk);
      bus(0, gtc_pkg::OFS_COUNT_LOW, 32'h0);
      chk(d, exp_t[r], exp_t[r]);
    end
    close_out();
  end
endmodule // gtc_timer_tb_top
`default_nettype wire
